// >>> tcmp_pkg.sv
/*
  Shared constants and types for the temperature threshold compare block:
  register pointers, field masks, reset values, hysteresis steps and the
  structs that carry configuration and trip flags.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package tcmp_pkg;

  // register pointers
  localparam logic [7:0] PTR_UPPER = 8'h02;
  localparam logic [7:0] PTR_LOWER = 8'h03;
  localparam logic [7:0] PTR_CRIT = 8'h04;
  localparam logic [7:0] PTR_TEMP = 8'h05;
  localparam logic [7:0] PTR_MAKER = 8'h06;
  localparam logic [7:0] PTR_PART = 8'h07;

  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [15:0] TEMP_RST = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // bits that may hold a one; everything else reads as zero, except the trip flags that 05h reads in bits 15:13
  localparam logic [15:0] LIMIT_MASK = 16'h1ffc;
  localparam logic [15:0] TEMP_MASK = 16'h1ffe;

  // value field: sign at bit 12, bit 0 weighs 0.0625 degrees
  localparam int VAL_W = 13;
  localparam int VAL_MSB = 12;
  localparam int FLAG_CRIT_BIT = 15;
  localparam int FLAG_ABOVE_BIT = 14;
  localparam int FLAG_BELOW_BIT = 13;

  // hysteresis select codes and amounts in bit-0 units (0.0625 degrees)
  localparam logic [1:0] HSEL_OFF = 2'h0;
  localparam logic [1:0] HSEL_1P5 = 2'h1;
  localparam logic [1:0] HSEL_3 = 2'h2;
  localparam logic [1:0] HSEL_6 = 2'h3;
  localparam logic [VAL_W:0] HYST_OFF = 14'h0000;
  localparam logic [VAL_W:0] HYST_1P5 = 14'h0018;
  localparam logic [VAL_W:0] HYST_3 = 14'h0030;
  localparam logic [VAL_W:0] HYST_6 = 14'h0060;

  typedef enum logic [1:0] {
    PH_POINTER,
    PH_MSB,
    PH_LSB
  } tcmp_phase_e;

  typedef struct packed {
    logic [1:0] hyst_sel;
    logic alarm_lock;
    logic crit_lock;
  } tcmp_cfg_s;

  typedef struct packed {
    logic crit;
    logic above;
    logic below;
  } tcmp_trip_s;

endpackage : tcmp_pkg

`default_nettype wire

// >>> tcmp_limit_reg.sv
/*
  One 16-bit threshold register with write lock.
  Assumes wr_en is a one-cycle strobe carrying a whole word and that the
  lock level is held by the configuration logic outside.
*/
`timescale 1ns/1ps
`default_nettype none

module tcmp_limit_reg (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic lock,
  output var logic [15:0] value_r
);

  logic [15:0] value_nxt;

  always_comb begin
    value_nxt = value_r;
    if (wr_en && !lock) begin
      value_nxt = wr_data & tcmp_pkg::LIMIT_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= tcmp_pkg::LIMIT_RST;
    end else begin
      value_r <= value_nxt;
    end
  end

endmodule : tcmp_limit_reg

`default_nettype wire

// >>> tcmp_trip.sv
/*
  Hysteresis comparators for the three trip flags.
  Assumes sample_en pulses once per new temperature result and that the
  limits and temperature share bit weights in their low 13 bits.
*/
`timescale 1ns/1ps
`default_nettype none

module tcmp_trip (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_en,
  input wire logic [15:0] temp,
  input wire logic [15:0] upper,
  input wire logic [15:0] lower,
  input wire logic [15:0] crit,
  input wire logic [1:0] hyst_sel,
  output var tcmp_pkg::tcmp_trip_s trip_r
);

  // sign-extend the value field by one bit so subtraction cannot wrap
  function automatic logic signed [tcmp_pkg::VAL_W:0] ext(
    input logic [15:0] w
  );
    ext = {w[tcmp_pkg::VAL_MSB], w[tcmp_pkg::VAL_MSB:0]};
  endfunction : ext

  tcmp_pkg::tcmp_trip_s trip_nxt;
  logic signed [tcmp_pkg::VAL_W:0] hyst;
  logic signed [tcmp_pkg::VAL_W:0] t;
  logic signed [tcmp_pkg::VAL_W:0] up;
  logic signed [tcmp_pkg::VAL_W:0] lo;
  logic signed [tcmp_pkg::VAL_W:0] cr;

  always_comb begin
    unique case (hyst_sel)
      tcmp_pkg::HSEL_OFF: hyst = tcmp_pkg::HYST_OFF;
      tcmp_pkg::HSEL_1P5: hyst = tcmp_pkg::HYST_1P5;
      tcmp_pkg::HSEL_3: hyst = tcmp_pkg::HYST_3;
      tcmp_pkg::HSEL_6: hyst = tcmp_pkg::HYST_6;
    endcase
    t = ext(temp);
    up = ext(upper);
    lo = ext(lower);
    cr = ext(crit);
    trip_nxt = trip_r;
    if (sample_en) begin
      if (t > up) begin
        trip_nxt.above = 1'b1;
      end else if (t <= up - hyst) begin
        trip_nxt.above = 1'b0;
      end
      if (t < lo - hyst) begin
        trip_nxt.below = 1'b1;
      end else if (t >= lo) begin
        trip_nxt.below = 1'b0;
      end
      if (t >= cr) begin
        trip_nxt.crit = 1'b1;
      end else if (t < cr - hyst) begin
        trip_nxt.crit = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_r <= '0;
    end else begin
      trip_r <= trip_nxt;
    end
  end

endmodule : tcmp_trip

`default_nettype wire

// >>> tcmp_regs.sv
/*
  Threshold compare register bank: byte-wide register port behind the
  two-wire bus engine, three locked limit registers, the temperature result
  with trip flags, and the two identification registers.
  Assumes the bus engine marks each transaction with bus_start, delivers
  written bytes as one-cycle strobes and asks for read bytes one at a time.
*/
// Function
// - upper limit at 02h, read/write, resets zero
// - limits: sign bit 12, bits 15:13,1:0 zero
// - lower limit at 03h, same format, resets zero
// - critical limit at 04h, same format, resets zero
// - temperature read-only at 05h, 0.125 degree steps
// - trip flags depend only on comparisons
// - both window flags clear means not over upper and not under lower-hyst
// - below flag: set under lower-hyst, clear at lower
// - above flag: set over upper, clear at upper-hyst
// - critical flag: set at limit, clear below limit-hyst
// - maker identifier read-only at 06h, writes ignored
// - 07h: part identifier high byte, revision low
// - two-bit hysteresis: none, 1.5, 3, 6 degrees
// - alarm lock blocks upper and lower writes
// - critical lock blocks critical limit writes
`timescale 1ns/1ps
`default_nettype none

module tcmp_regs #(
  parameter logic [15:0] MAKER_ID = 16'h0a5c, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h3c, // arbitrary value
  parameter logic [7:0] PART_REV = 8'h01 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_start,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic rd_req,
  input wire logic temp_valid,
  input wire logic [15:0] temp_in,
  input wire tcmp_pkg::tcmp_cfg_s cfg,
  output var logic [7:0] rd_byte_r,
  output var logic rd_valid_r,
  output var tcmp_pkg::tcmp_trip_s trip_r
);

  tcmp_pkg::tcmp_phase_e phase_r;
  tcmp_pkg::tcmp_phase_e phase_nxt;
  tcmp_pkg::tcmp_phase_e phase_eff;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] msb_hold_r;
  logic [7:0] msb_hold_nxt;
  logic rd_lsb_r;
  logic rd_lsb_nxt;
  logic [7:0] rd_snap_r;
  logic [7:0] rd_snap_nxt;
  logic [7:0] rd_byte_nxt;
  logic rd_valid_nxt;
  logic [15:0] temp_r;
  logic [15:0] temp_nxt;
  logic [15:0] temp_masked;
  logic wr_commit;
  logic [15:0] wr_word;
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [15:0] crit_q;
  logic [15:0] read_word;

  // byte sequencing: pointer first, then MSB/LSB pairs
  always_comb begin
    phase_eff = bus_start ? tcmp_pkg::PH_POINTER : phase_r;
    phase_nxt = phase_eff;
    ptr_nxt = ptr_r;
    msb_hold_nxt = msb_hold_r;
    wr_commit = 1'b0;
    wr_word = {msb_hold_r, wr_byte};
    if (wr_valid) begin
      unique case (phase_eff)
        tcmp_pkg::PH_POINTER: begin
          ptr_nxt = wr_byte;
          phase_nxt = tcmp_pkg::PH_MSB;
        end
        tcmp_pkg::PH_MSB: begin
          msb_hold_nxt = wr_byte;
          phase_nxt = tcmp_pkg::PH_LSB;
        end
        tcmp_pkg::PH_LSB: begin
          wr_commit = 1'b1;
          phase_nxt = tcmp_pkg::PH_MSB;
        end
        default: phase_nxt = tcmp_pkg::PH_POINTER;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= tcmp_pkg::PH_POINTER;
      ptr_r <= '0;
      msb_hold_r <= '0;
    end else begin
      phase_r <= phase_nxt;
      ptr_r <= ptr_nxt;
      msb_hold_r <= msb_hold_nxt;
    end
  end

  tcmp_limit_reg u_upper (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_commit && ptr_r == tcmp_pkg::PTR_UPPER),
    .wr_data(wr_word),
    .lock(cfg.alarm_lock),
    .value_r(upper_q)
  );

  tcmp_limit_reg u_lower (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_commit && ptr_r == tcmp_pkg::PTR_LOWER),
    .wr_data(wr_word),
    .lock(cfg.alarm_lock),
    .value_r(lower_q)
  );

  tcmp_limit_reg u_crit (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_commit && ptr_r == tcmp_pkg::PTR_CRIT),
    .wr_data(wr_word),
    .lock(cfg.crit_lock),
    .value_r(crit_q)
  );

  // temperature result; no bus write reaches it
  always_comb begin
    temp_masked = temp_in & tcmp_pkg::TEMP_MASK;
    temp_nxt = temp_valid ? temp_masked : temp_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_r <= tcmp_pkg::TEMP_RST;
    end else begin
      temp_r <= temp_nxt;
    end
  end

  // flags see only the sample, limits and hysteresis select
  tcmp_trip u_trip (
    .clk(clk),
    .rst_n(rst_n),
    .sample_en(temp_valid),
    .temp(temp_masked),
    .upper(upper_q),
    .lower(lower_q),
    .crit(crit_q),
    .hyst_sel(cfg.hyst_sel),
    .trip_r(trip_r)
  );

  always_comb begin
    read_word = tcmp_pkg::UNMAPPED_READ;
    unique case (ptr_r)
      tcmp_pkg::PTR_UPPER: read_word = upper_q;
      tcmp_pkg::PTR_LOWER: read_word = lower_q;
      tcmp_pkg::PTR_CRIT: read_word = crit_q;
      tcmp_pkg::PTR_TEMP: begin
        read_word = temp_r;
        read_word[tcmp_pkg::FLAG_CRIT_BIT] = trip_r.crit;
        read_word[tcmp_pkg::FLAG_ABOVE_BIT] = trip_r.above;
        read_word[tcmp_pkg::FLAG_BELOW_BIT] = trip_r.below;
      end
      tcmp_pkg::PTR_MAKER: read_word = MAKER_ID;
      tcmp_pkg::PTR_PART: read_word = {PART_ID, PART_REV};
      default: read_word = tcmp_pkg::UNMAPPED_READ;
    endcase
  end

  // reads: MSB first, LSB snapshotted so the word stays coherent
  always_comb begin
    rd_lsb_nxt = bus_start ? 1'b0 : rd_lsb_r;
    rd_snap_nxt = rd_snap_r;
    rd_byte_nxt = rd_byte_r;
    rd_valid_nxt = rd_req;
    if (wr_valid) begin
      rd_lsb_nxt = 1'b0;
    end
    if (rd_req) begin
      if (!rd_lsb_nxt) begin
        rd_byte_nxt = read_word[15:8];
        rd_snap_nxt = read_word[7:0];
        rd_lsb_nxt = 1'b1;
      end else begin
        rd_byte_nxt = rd_snap_r;
        rd_lsb_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_lsb_r <= 1'b0;
      rd_snap_r <= '0;
      rd_byte_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_lsb_r <= rd_lsb_nxt;
      rd_snap_r <= rd_snap_nxt;
      rd_byte_r <= rd_byte_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

endmodule : tcmp_regs

`default_nettype wire

// >>> tcmp_regs_asserts.sv
/* Port checker for tcmp_regs: read handshake and trip flag timing.
   Assumes it is bound to every tcmp_regs instance. */
`timescale 1ns/1ps
`default_nettype none
module tcmp_regs_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_start,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic rd_req,
  input wire logic temp_valid,
  input wire logic [15:0] temp_in,
  input wire tcmp_pkg::tcmp_cfg_s cfg,
  input wire logic [7:0] rd_byte_r,
  input wire logic rd_valid_r,
  input wire tcmp_pkg::tcmp_trip_s trip_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence two_reads; rd_req ##1 rd_req; endsequence
  sequence new_sample; temp_valid ##1 !temp_valid; endsequence
  sequence quiet; !temp_valid ##1 !temp_valid; endsequence
  chk_rd_answer: assert property (rd_req |=> rd_valid_r)
    else $error("read answer missing");
  chk_rd_pulse: assert property (!rd_req |=> !rd_valid_r)
    else $error("read valid without request");
  property write_stays_silent;
    wr_valid && !rd_req |=> !rd_valid_r;
  endproperty
  property pair_answered;
    two_reads |-> rd_valid_r ##1 rd_valid_r;
  endproperty
  property byte_moves_on_read;
    $changed(rd_byte_r) |-> $past(rd_req);
  endproperty
  property trip_moves_on_sample;
    $changed(trip_r) |-> $past(temp_valid);
  endproperty
  chk_wr_silent: assert property (write_stays_silent)
    else $error("write produced a read answer");
  chk_pair_read: assert property (pair_answered)
    else $error("back to back reads not both answered");
  chk_byte_stand: assert property (byte_moves_on_read)
    else $error("read byte moved without request");
  chk_trip_cause: assert property (trip_moves_on_sample)
    else $error("trip flags moved without sample");
  chk_trip_quiet: assert property (quiet |-> $stable(trip_r))
    else $error("trip flags moved between samples");
  chk_trip_hold: assert property (new_sample |=> $stable(trip_r))
    else $error("trip flags moved after sample");
endmodule : tcmp_regs_asserts
bind tcmp_regs tcmp_regs_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .bus_start(bus_start), .wr_valid(wr_valid), .wr_byte(wr_byte),
  .rd_req(rd_req), .temp_valid(temp_valid), .temp_in(temp_in),
  .cfg(cfg), .rd_byte_r(rd_byte_r), .rd_valid_r(rd_valid_r),
  .trip_r(trip_r));
`default_nettype wire

// >>> tcmp_host.sv
/* Host model: two-wire bus master as seen at the byte port.
   Assumes the bank answers each rd_req one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module tcmp_host (
  input wire logic clk,
  input wire logic [7:0] rd_byte_r,
  output logic bus_start,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic rd_req
);
  initial begin
    bus_start = 1'b0;
    wr_valid = 1'b0;
    wr_byte = 8'h00;
    rd_req = 1'b0;
  end
  // pointer, then MSB, then LSB
  task automatic put(input logic [7:0] p, input logic [15:0] d);
    @(posedge clk);
    bus_start <= 1'b1;
    wr_valid <= 1'b1;
    wr_byte <= p;
    @(posedge clk);
    bus_start <= 1'b0;
    wr_byte <= d[15:8];
    @(posedge clk);
    wr_byte <= d[7:0];
    @(posedge clk);
    wr_valid <= 1'b0;
    wr_byte <= ~d[7:0];
  endtask : put
  // pointer, then two reads, MSB first
  task automatic get(input logic [7:0] p, output logic [15:0] d);
    @(posedge clk);
    bus_start <= 1'b1;
    wr_valid <= 1'b1;
    wr_byte <= p;
    @(posedge clk);
    bus_start <= 1'b0;
    wr_valid <= 1'b0;
    wr_byte <= ~p;
    rd_req <= 1'b1;
    @(posedge clk);
    #1 d[15:8] = rd_byte_r;
    @(posedge clk);
    rd_req <= 1'b0;
    #1 d[7:0] = rd_byte_r;
  endtask : get
endmodule : tcmp_host
`default_nettype wire

// >>> tcmp_regs_bench.sv
/* Self-checking bench for tcmp_regs.
   Assumes tcmp_host drives the byte port; the bench drives samples. */
`timescale 1ns/1ps
`default_nettype none
module tcmp_regs_bench;
  logic clk, rst_n, bus_start, wr_valid, rd_req, temp_valid, rd_valid_r;
  logic [7:0] wr_byte, rd_byte_r;
  logic [15:0] temp_in, rd;
  tcmp_pkg::tcmp_cfg_s cfg;
  tcmp_pkg::tcmp_trip_s trip_r;
  int miscompares = 0;
  int check_count = 0;
  localparam logic [15:0] MAKER = 16'h1357; // arbitrary value
  localparam logic [7:0] PART = 8'h9a; // arbitrary value
  localparam logic [7:0] REV = 8'h02; // arbitrary value
  localparam logic [15:0] HY [4] = '{16'h0, 16'h18, 16'h30, 16'h60};
  localparam logic [15:0] TV [9] = '{16'h0500, 16'h0600, 16'h05d0,
    16'h05ce, 16'h00d0, 16'h00ce, 16'h00fe, 16'h0100, 16'he601};
  localparam logic [2:0] EV [9] = '{3'h0, 3'h6, 3'h6, 3'h2, 3'h0, 3'h1,
    3'h1, 3'h0, 3'h6};
  tcmp_regs #(.MAKER_ID(MAKER), .PART_ID(PART), .PART_REV(REV)) dut (
    .clk(clk), .rst_n(rst_n), .bus_start(bus_start), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .rd_req(rd_req), .temp_valid(temp_valid),
    .temp_in(temp_in), .cfg(cfg), .rd_byte_r(rd_byte_r),
    .rd_valid_r(rd_valid_r), .trip_r(trip_r));
  tcmp_host host (.clk(clk), .rd_byte_r(rd_byte_r), .bus_start(bus_start),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rdchk(input logic [7:0] p, input logic [15:0] exp);
    host.get(p, rd);
    chk(rd, exp);
    chk({15'h0000, rd_valid_r}, 16'h0001);
  endtask : rdchk
  task samp(input logic [1:0] hs, input logic [15:0] t, input logic [2:0] e);
    @(posedge clk);
    cfg.hyst_sel <= hs;
    temp_valid <= 1'b1;
    temp_in <= t;
    @(posedge clk);
    temp_valid <= 1'b0;
    temp_in <= ~t;
    @(posedge clk);
    #1 chk({13'h0, trip_r}, {13'h0, e});
  endtask : samp
  task print_verdict;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task test_reset;
    for (int p = 2; p < 6; p++) begin
      rdchk(p[7:0], 16'h0000);
    end
    rdchk(8'h06, MAKER);
    rdchk(8'h07, {PART, REV});
    $display("test_reset done");
  endtask : test_reset
  task test_limits;
    host.put(8'h02, 16'hffff);
    rdchk(8'h02, 16'h1ffc);
    host.put(8'h03, 16'ha5a7);
    rdchk(8'h03, 16'h05a4);
    host.put(8'h04, 16'h1234);
    rdchk(8'h04, 16'h1234);
    for (int p = 5; p < 9; p++) host.put(p[7:0], 16'hffff);
    rdchk(8'h05, 16'h0000);
    rdchk(8'h06, MAKER);
    rdchk(8'h07, {PART, REV});
    rdchk(8'h08, 16'h0000);
    $display("test_limits done");
  endtask : test_limits
  task test_trip;
    host.put(8'h02, 16'h0500);
    host.put(8'h03, 16'h0100);
    host.put(8'h04, 16'h0600);
    for (int c = 0; c < 4; c++) begin
      samp(c[1:0], 16'h0502, 3'h2);
      samp(c[1:0], 16'h0502 - HY[c], 3'h2);
      samp(c[1:0], 16'h0500 - HY[c], 3'h0);
    end
    for (int i = 0; i < 9; i++) begin
      samp(2'h2, TV[i], EV[i]);
    end
    rdchk(8'h05, 16'hc600);
    $display("test_trip done");
  endtask : test_trip
  task test_lock;
    @(posedge clk);
    cfg.alarm_lock <= 1'b1;
    cfg.hyst_sel <= 2'h3;
    host.put(8'h02, 16'h0100);
    host.put(8'h03, 16'h0200);
    host.put(8'h04, 16'h0700);
    rdchk(8'h02, 16'h0500);
    rdchk(8'h03, 16'h0100);
    rdchk(8'h04, 16'h0700);
    @(posedge clk);
    cfg.crit_lock <= 1'b1;
    host.put(8'h04, 16'h0100);
    rdchk(8'h04, 16'h0700);
    chk({13'h0, trip_r}, 16'h0006);
    $display("test_lock done");
  endtask : test_lock
  initial begin
    rst_n = 1'b0;
    temp_valid = 1'b0;
    temp_in = 16'h0000;
    cfg = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_limits();
    test_trip();
    test_lock();
    print_verdict();
  end
  initial begin
    // about ten times the expected length of all tests
    #200000;
    miscompares++;
    print_verdict();
  end
endmodule : tcmp_regs_bench
`default_nettype wire
